// ===== common/sbc_pkg.sv
/*
  Shared constants for the converter bus controller: register offsets, field positions,
  reset values, timing counts and the sequencer state type.
  Assumes a 20 MHz ref_clk and a converter whose control strobes are driven by this controller.
*/
// Summary of operation
// - Start strobe held low at least 300 ns.
// - Read_not_write low starts, high reads result.
// - Deselecting either strobe ends the read.
// - Hold bipolar select low for unipolar.
// - Hold bipolar select high for bipolar.
package sbc_pkg;

  // ----------------------------------------------------------------
  // Register map, byte offsets on the AXI4-Lite bus.
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
  localparam logic [7:0] REG_IRQ_MASK = 8'h10;

  // ----------------------------------------------------------------
  // Field positions and reset values.
  // ----------------------------------------------------------------
  localparam int CTRL_START = 0;
  localparam int CTRL_BIPOLAR = 1;
  localparam int CTRL_CODE = 2;
  localparam int CTRL_CONT = 3;
  localparam int STAT_BUSY = 0;
  localparam int STAT_PIN = 1;
  localparam int STAT_VALID = 2;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_IGNORED = 1;
  localparam int IRQ_BITS = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Bus responses.
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Timing: figures in ns, counts derived from the clock period.
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int START_PULSE_NS = 300;
  localparam int STATUS_RISE_NS = 1000;
  localparam int READ_ACCESS_NS = 250;
  localparam int START_PULSE_CYC = (START_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STATUS_RISE_CYC = (STATUS_RISE_NS / CLK_PERIOD_NS < 1) ? 1 : STATUS_RISE_NS / CLK_PERIOD_NS;
  localparam int READ_ACCESS_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Sequencer states.
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_WR_SETUP = 4'h1,
    ST_WR_STROBE = 4'h2,
    ST_WAIT_RISE = 4'h3,
    ST_WAIT_FALL = 4'h4,
    ST_RD_SETUP = 4'h5,
    ST_RD_STROBE = 4'h6,
    ST_RD_END = 4'h7
  } sbc_state_type;

endpackage : sbc_pkg

// ===== logic/sbc_axil_slave.sv
/*
  AXI4-Lite slave front end: turns bus channel handshakes into one-cycle register
  write and read requests. Assumes the parent answers a request combinationally.
*/
`timescale 1ns/10ps
`default_nettype none
module sbc_axil_slave
  import sbc_pkg::*;
(
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Write address and data channels.
  input wire logic [ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  // Write response channel.
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // Read channels.
  input wire logic [ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Register side.
  output logic wr_req,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_err,
  output logic rd_req,
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);

  // ----------------------------------------------------------------
  // Holding state for the write pair and the two responses.
  // ----------------------------------------------------------------
  logic aw_held, next_aw_held; // Write address captured.
  logic w_held, next_w_held; // Write data captured.
  logic [ADDR_W-1:0] next_wr_addr;
  logic [31:0] next_wr_data;
  logic [3:0] next_wr_strb;
  logic [1:0] next_bresp, next_rresp;
  logic next_bvalid, next_rvalid;
  logic [31:0] next_rdata;

  // Channels accept only while nothing is pending, so one write and one read at most.
  assign s_awready = !aw_held && !s_bvalid;
  assign s_wready = !w_held && !s_bvalid;
  assign s_arready = !s_rvalid;
  // The write is performed once both halves are held, whichever came first.
  assign wr_req = aw_held && w_held && !s_bvalid;
  assign rd_req = s_arvalid && s_arready;
  assign rd_addr = s_araddr;

  // Next values of the channel state.
  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_wr_strb = wr_strb;
    next_bvalid = s_bvalid;
    next_bresp = s_bresp;
    next_rvalid = s_rvalid;
    next_rresp = s_rresp;
    next_rdata = s_rdata;
    if (s_awvalid && s_awready) begin
      next_aw_held = 1'b1;
      next_wr_addr = s_awaddr;
    end
    if (s_wvalid && s_wready) begin
      next_w_held = 1'b1;
      next_wr_data = s_wdata;
      next_wr_strb = s_wstrb;
    end
    if (wr_req) begin
      // Response is registered; the halves are freed when it is taken.
      next_bvalid = 1'b1;
      next_bresp = wr_err ? RESP_SLVERR : RESP_OKAY;
    end else if (s_bvalid && s_bready) begin
      next_bvalid = 1'b0;
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
    end
    if (rd_req) begin
      next_rvalid = 1'b1;
      next_rdata = rd_data;
      next_rresp = rd_err ? RESP_SLVERR : RESP_OKAY;
    end else if (s_rvalid && s_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // Register stage.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= '0;
      wr_data <= 32'h0;
      wr_strb <= 4'h0;
      s_bvalid <= 1'b0;
      s_bresp <= RESP_OKAY;
      s_rvalid <= 1'b0;
      s_rresp <= RESP_OKAY;
      s_rdata <= 32'h0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      wr_strb <= next_wr_strb;
      s_bvalid <= next_bvalid;
      s_bresp <= next_bresp;
      s_rvalid <= next_rvalid;
      s_rresp <= next_rresp;
      s_rdata <= next_rdata;
    end
  end

endmodule : sbc_axil_slave
`default_nettype wire

// ===== logic/sbc_host_ctrl.sv
/*
  Host-side controller for a bus-interfaced 8-bit converter: software orders a conversion
  over AXI4-Lite, the controller drives the chip strobes, waits out the status line,
  reads the result and raises an interrupt.
  Assumes converter pins synchronous to ref_clk and the data bus floated by the converter
  whenever it is not being read.
*/
`timescale 1ns/10ps
`default_nettype none
module sbc_host_ctrl
  import sbc_pkg::*;
#(
  parameter int START_CYC = START_PULSE_CYC,
  parameter int RISE_CYC = STATUS_RISE_CYC,
  parameter int READ_CYC = READ_ACCESS_CYC
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // AXI4-Lite write channels.
  input wire logic [ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // AXI4-Lite read channels.
  input wire logic [ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Converter control pins.
  output logic adc_chip_enable_n,
  output logic adc_select_n,
  output logic adc_read_not_write,
  output logic adc_bipolar_select,
  output logic adc_output_code_select,
  // Converter status and data pins.
  input wire logic adc_status,
  input wire logic [7:0] adc_data,
  // Interrupt.
  output logic irq
);

  // ----------------------------------------------------------------
  // Parameter checks.
  // ----------------------------------------------------------------
  // The down-counter is eight bits wide, and a zero count would wrap its load to 255 and stretch the strobe or wait.
  // The start load carries one cycle of margin on top, so it must still fit eight bits.
  initial begin
    if (START_CYC < START_PULSE_CYC || START_CYC > 254 || RISE_CYC < 1 || RISE_CYC > 255 ||
        READ_CYC < 1 || READ_CYC > 255) begin
      $error("sbc_host_ctrl: timing parameter out of range");
    end
  end

  // The selects stay low for START_LOAD cycles, so START_CYC + 1 keeps the pulse above the minimum.
  localparam logic [7:0] START_LOAD = 8'(START_CYC + 1);
  localparam logic [7:0] RISE_LOAD = 8'(RISE_CYC - 1);
  localparam logic [7:0] READ_LOAD = 8'(READ_CYC - 1);

  // ----------------------------------------------------------------
  // Register decode.
  // ----------------------------------------------------------------
  // True for any offset that holds a register; used by both read and write paths.
  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    is_mapped = (addr == REG_CTRL) || (addr == REG_STATUS) || (addr == REG_DATA) ||
                (addr == REG_IRQ_STAT) || (addr == REG_IRQ_MASK);
  endfunction : is_mapped

  // ----------------------------------------------------------------
  // Bus front end.
  // ----------------------------------------------------------------
  logic wr_req; // One-cycle register write.
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_err;
  logic rd_req; // One-cycle register read.
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_err;

  sbc_axil_slave u_bus (
    .ref_clk(ref_clk),
    .rst(rst),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .wr_req(wr_req),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_err(wr_err),
    .rd_req(rd_req),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  // ----------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------
  sbc_state_type state, next_state; // Sequencer position.
  logic [7:0] count, next_count; // Down-counter for strobe and wait times.
  logic [2:0] ctrl, next_ctrl; // Stored bipolar, code and continuous bits.
  logic [7:0] result, next_result; // Last result read from the converter.
  logic valid, next_valid; // Result register holds a fresh value.
  logic [IRQ_BITS-1:0] irq_stat, next_irq_stat; // Sticky event bits.
  logic [IRQ_BITS-1:0] irq_mask, next_irq_mask; // Interrupt enables.
  logic [IRQ_BITS-1:0] irq_set; // Events of this cycle.
  logic [IRQ_BITS-1:0] irq_clr; // Write-one-to-clear of this cycle.
  logic next_ce_n, next_cs_n, next_rnw; // Strobe pin next values.
  logic next_bip, next_code; // Mode pin next values.
  logic start_req; // Software asked for a conversion.
  logic wr_byte0; // Write touches the low byte.

  assign wr_byte0 = wr_req && wr_strb[0];
  assign start_req = wr_byte0 && (wr_addr == REG_CTRL) && wr_data[CTRL_START];
  assign wr_err = !is_mapped(wr_addr);

  // ----------------------------------------------------------------
  // Read path.
  // ----------------------------------------------------------------
  // Unmapped offsets answer SLVERR with zero data; unused bits read as zero.
  always_comb begin
    rd_data = 32'h0;
    rd_err = 1'b0;
    case (rd_addr)
      REG_CTRL: rd_data[CTRL_CONT:CTRL_BIPOLAR] = ctrl;
      REG_STATUS: begin
        rd_data[STAT_BUSY] = (state != ST_IDLE);
        rd_data[STAT_PIN] = adc_status;
        rd_data[STAT_VALID] = valid;
      end
      REG_DATA: rd_data[7:0] = result;
      REG_IRQ_STAT: rd_data[IRQ_BITS-1:0] = irq_stat;
      REG_IRQ_MASK: rd_data[IRQ_BITS-1:0] = irq_mask;
      default: rd_err = !is_mapped(rd_addr);
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer.
  // ----------------------------------------------------------------
  // Strobes are registered so the pins never glitch; read_not_write is always settled
  // one cycle before the selects fall, so the converter sees one operation only.
  always_comb begin
    next_state = state;
    next_count = count;
    next_ce_n = adc_chip_enable_n;
    next_cs_n = adc_select_n;
    next_rnw = adc_read_not_write;
    next_bip = adc_bipolar_select;
    next_code = adc_output_code_select;
    next_result = result;
    next_valid = valid;
    irq_set = '0;
    // A start while the sequence runs is refused and reported, never queued.
    if (start_req && state != ST_IDLE) begin
      irq_set[IRQ_IGNORED] = 1'b1;
    end
    case (state)
      ST_IDLE: begin
        // Selects released and data bus left alone until software orders a start.
        next_ce_n = 1'b1;
        next_cs_n = 1'b1;
        next_rnw = 1'b1;
        if (start_req) begin
          // Mode pins are set up before the strobe so they are sampled at start.
          next_bip = wr_data[CTRL_BIPOLAR];
          next_code = wr_data[CTRL_CODE];
          next_valid = 1'b0;
          next_state = ST_WR_SETUP;
        end
      end
      ST_WR_SETUP: begin
        next_rnw = 1'b0;
        next_state = ST_WR_STROBE;
        next_count = START_LOAD;
      end
      ST_WR_STROBE: begin
        // Both selects are low for at least the minimum start pulse.
        next_ce_n = 1'b0;
        next_cs_n = 1'b0;
        if (count != 8'h00) begin
          next_count = count - 8'h01;
        end else if (!ctrl[CTRL_CONT - 1]) begin
          // Continuous mode keeps all three low so the converter reconverts.
          next_ce_n = 1'b1;
          next_cs_n = 1'b1;
          next_count = RISE_LOAD;
          next_state = ST_WAIT_RISE;
        end
      end
      ST_WAIT_RISE: begin
        // Status may already have come and gone in a short part; give up after a bound.
        if (adc_status || count == 8'h00) begin
          next_state = ST_WAIT_FALL;
        end else begin
          next_count = count - 8'h01;
        end
      end
      ST_WAIT_FALL: begin
        // Never read while status is high: the outputs stay floated then.
        if (!adc_status) begin
          next_rnw = 1'b1;
          next_state = ST_RD_SETUP;
        end
      end
      ST_RD_SETUP: begin
        next_ce_n = 1'b0;
        next_cs_n = 1'b0;
        next_count = READ_LOAD;
        next_state = ST_RD_STROBE;
      end
      ST_RD_STROBE: begin
        if (count != 8'h00) begin
          next_count = count - 8'h01;
        end else begin
          // Sample at the end of the access time, then release both selects.
          next_result = adc_data;
          next_valid = 1'b1;
          next_ce_n = 1'b1;
          next_cs_n = 1'b1;
          next_state = ST_RD_END;
        end
      end
      ST_RD_END: begin
        irq_set[IRQ_DONE] = 1'b1;
        next_state = ST_IDLE;
      end
      default: begin
        next_ce_n = 1'b1;
        next_cs_n = 1'b1;
        next_rnw = 1'b1;
        next_state = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Software registers.
  // ----------------------------------------------------------------
  // Control bits may change at any time; bipolar and code reach the pins only at the next start, while the continuous bit acts at once.
  always_comb begin
    next_ctrl = ctrl;
    next_irq_mask = irq_mask;
    irq_clr = '0;
    if (wr_byte0) begin
      case (wr_addr)
        REG_CTRL: next_ctrl = wr_data[CTRL_CONT:CTRL_BIPOLAR];
        REG_IRQ_MASK: next_irq_mask = wr_data[IRQ_BITS-1:0];
        REG_IRQ_STAT: irq_clr = wr_data[IRQ_BITS-1:0];
        default: next_ctrl = ctrl;
      endcase
    end
  end

  // Each sticky bit is set by its event and cleared by a written one; set wins.
  genvar gi;
  generate
    for (gi = 0; gi < IRQ_BITS; gi++) begin : g_irq
      assign next_irq_stat[gi] = irq_set[gi] | (irq_stat[gi] & ~irq_clr[gi]);
    end
  endgenerate

  assign irq = |(irq_stat & irq_mask);

  // ----------------------------------------------------------------
  // Register stage.
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= ST_IDLE;
      count <= 8'h00;
      ctrl <= CTRL_RESET;
      result <= DATA_RESET;
      valid <= 1'b0;
      irq_stat <= IRQ_RESET;
      irq_mask <= IRQ_RESET;
      adc_chip_enable_n <= 1'b1;
      adc_select_n <= 1'b1;
      adc_read_not_write <= 1'b1;
      adc_bipolar_select <= 1'b0;
      adc_output_code_select <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      ctrl <= next_ctrl;
      result <= next_result;
      valid <= next_valid;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      adc_chip_enable_n <= next_ce_n;
      adc_select_n <= next_cs_n;
      adc_read_not_write <= next_rnw;
      adc_bipolar_select <= next_bip;
      adc_output_code_select <= next_code;
    end
  end

endmodule : sbc_host_ctrl
`default_nettype wire

// ===== sim/sbc_host_ctrl_monitor.sv
/* Pin checker for the converter bus controller.
   Assumes it is bound into sbc_host_ctrl. */
`timescale 1ns/10ps
`default_nettype none
module sbc_host_ctrl_monitor
  import sbc_pkg::*;
#(
  parameter int START_CYC = 6,
  parameter int READ_CYC = 5
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Converter pins.
  input wire logic adc_chip_enable_n,
  input wire logic adc_select_n,
  input wire logic adc_read_not_write,
  input wire logic adc_bipolar_select,
  input wire logic adc_output_code_select,
  input wire logic adc_status,
  // Interrupt.
  input wire logic irq
);
  // ----
  // Strobe length counter
  // ----
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Edges seen with the selects low; a strobe's length is read at its end.
  int low_cnt;
  int next_low_cnt;
  always_comb next_low_cnt = adc_select_n ? 0 : low_cnt + 1;
  always_ff @(posedge ref_clk) low_cnt <= rst ? 0 : next_low_cnt;
  a_selects_paired: assert property (adc_chip_enable_n == adc_select_n)
    else $error("selects differ");
  a_rnw_held: assert property ($changed(adc_read_not_write) |-> adc_select_n && $past(adc_select_n))
    else $error("rnw moved while selected");
  a_start_len: assert property ($rose(adc_select_n) && !adc_read_not_write |-> low_cnt == START_CYC + 1)
    else $error("start strobe length wrong");
  a_read_len: assert property ($rose(adc_select_n) && adc_read_not_write |-> low_cnt == READ_CYC)
    else $error("read strobe length wrong");
  a_read_idle: assert property ($fell(adc_select_n) && adc_read_not_write |-> !adc_status)
    else $error("read while busy");
  a_start_idle: assert property ($fell(adc_select_n) && !adc_read_not_write |-> !adc_status)
    else $error("start while busy");
  a_mode_steady: assert property (!adc_select_n |-> $stable(adc_bipolar_select) && $stable(adc_output_code_select))
    else $error("mode pins moved");
  a_read_follows: assert property ($fell(adc_status) |-> adc_select_n [*2] ##1 (!adc_select_n && adc_read_not_write))
    else $error("no read after status low");
  c_start: cover property ($rose(adc_select_n) && !adc_read_not_write);
  c_read: cover property ($rose(adc_select_n) && adc_read_not_write);
  c_irq: cover property ($rose(irq));
endmodule : sbc_host_ctrl_monitor
bind sbc_host_ctrl sbc_host_ctrl_monitor #(.START_CYC(START_CYC), .READ_CYC(READ_CYC)) u_monitor (
  .ref_clk(ref_clk), .rst(rst), .adc_chip_enable_n(adc_chip_enable_n), .adc_select_n(adc_select_n),
  .adc_read_not_write(adc_read_not_write), .adc_bipolar_select(adc_bipolar_select),
  .adc_output_code_select(adc_output_code_select), .adc_status(adc_status), .irq(irq));
`default_nettype wire

// ===== sim/sbc_adc_model.sv
/* Behavioural converter on the far side of the controller.
   Assumes strobes change just after ref_clk edges. */
`timescale 1ns/10ps
`default_nettype none
module sbc_adc_model
  import sbc_pkg::*;
(
  // Bench clock; the real part times itself.
  input wire logic ref_clk,
  // Strobes and mode pins.
  input wire logic chip_enable_n,
  input wire logic select_n,
  input wire logic read_not_write,
  input wire logic bipolar_select,
  input wire logic output_code_select,
  // Input level and a slow-conversion switch.
  input wire logic [7:0] analog_in,
  input wire logic slow,
  // Status and data.
  output logic status,
  output logic [7:0] data
);
  logic [5:0] low_cnt = 6'h00;
  logic [5:0] conv_cnt = 6'h00;
  logic [7:0] code = 8'h00;
  logic [7:0] last = 8'h00;
  logic bip_cap = 1'b0;
  logic fmt_cap = 1'b0;
  logic start_req;
  logic drive;
  // Trial each bit from the top, keeping it while the sum stays within the input.
  function automatic logic [7:0] sar(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 7; i >= 0; i--) begin
      if ((r | (8'h01 << i)) <= v) r = r | (8'h01 << i);
    end
    return r;
  endfunction : sar
  assign start_req = !chip_enable_n && !select_n && !read_not_write;
  assign status = conv_cnt != 6'h00;
  assign drive = !chip_enable_n && !select_n && read_not_write && !status;
  // A released bus toggles so a late sample can never look right.
  assign data = drive ? code : ~last;
  // Start needs six low samples; a running conversion cannot be touched.
  always @(posedge ref_clk) begin
    low_cnt <= start_req ? low_cnt + 6'h01 : 6'h00;
    last <= data;
    if (status) begin
      conv_cnt <= conv_cnt - 6'h01;
      if (conv_cnt == 6'h01) code <= sar(bip_cap ? analog_in + 8'h80 : analog_in) ^ {fmt_cap, 7'h00};
    end else if (start_req && low_cnt >= 6'h05) begin
      conv_cnt <= slow ? 6'h28 : 6'h0c;
      bip_cap <= bipolar_select;
      fmt_cap <= output_code_select;
    end
  end
endmodule : sbc_adc_model
`default_nettype wire

// ===== sim/testbench.sv
/* Self-checking bench for the converter bus controller.
   Assumes the converter model and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module testbench
  import sbc_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] s_awaddr = 8'h00;
  logic [7:0] s_araddr = 8'h00;
  logic [31:0] s_wdata = 32'h0;
  logic s_awvalid = 1'b0;
  logic s_wvalid = 1'b0;
  logic s_arvalid = 1'b0;
  logic s_bready = 1'b1;
  logic s_rready = 1'b1;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq;
  logic [1:0] s_bresp, s_rresp;
  logic [31:0] s_rdata;
  logic ce_n, sel_n, rnw, bip, fmt, status;
  logic [7:0] data;
  logic [7:0] vin = 8'h00;
  logic slow = 1'b0;
  logic [7:0] regs[5] = '{REG_CTRL, REG_STATUS, REG_DATA, REG_IRQ_STAT, REG_IRQ_MASK};
  logic [33:0] exp_q[$];
  int miscompares = 0;
  int checks_done = 0;
  initial forever #25 ref_clk = ~ref_clk;
  sbc_host_ctrl #(.START_CYC(6), .RISE_CYC(2), .READ_CYC(1)) u_dut (
    .ref_clk(ref_clk), .rst(rst), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(4'hf), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .adc_chip_enable_n(ce_n), .adc_select_n(sel_n), .adc_read_not_write(rnw), .adc_bipolar_select(bip),
    .adc_output_code_select(fmt), .adc_status(status), .adc_data(data), .irq(irq));
  sbc_adc_model u_adc (.ref_clk(ref_clk), .chip_enable_n(ce_n), .select_n(sel_n), .read_not_write(rnw),
    .bipolar_select(bip), .output_code_select(fmt), .analog_in(vin), .slow(slow), .status(status), .data(data));
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  // Bus writes: both halves offered together, each dropped once taken.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back({r, 32'h0});
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (!s_bvalid);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back({r, d});
    s_araddr <= a;
    s_arvalid <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_arready) s_arvalid <= 1'b0;
    end while (!s_rvalid);
  endtask : axi_rd
  // Each answer taken off the bus is matched with the oldest note.
  always @(posedge ref_clk) begin
    if (s_bvalid && s_bready) check({s_bresp, 32'h0}, exp_q.pop_front());
    if (s_rvalid && s_rready) check({s_rresp, s_rdata}, exp_q.pop_front());
  end
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    check(34'(irq), 34'h1);
  endtask : wait_irq
  // One conversion with a random input; the result is coded as the mode asks.
  task automatic convert(input logic b, input logic c);
    logic [7:0] v;
    logic [7:0] e;
    v = 8'($urandom);
    vin <= v;
    e = (b ? v + 8'h80 : v) ^ {c, 7'h00};
    axi_wr(REG_CTRL, {29'h0, c, b, 1'b1}, RESP_OKAY);
    check(34'({bip, fmt}), 34'({b, c}));
    wait_irq();
    axi_rd(REG_DATA, {24'h0, e}, RESP_OKAY);
    axi_rd(REG_STATUS, 32'h4, RESP_OKAY);
    axi_wr(REG_IRQ_STAT, 32'h1, RESP_OKAY);
    check(34'(irq), 34'h0);
  endtask : convert
  initial begin
    void'($urandom(18));
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (regs[i]) axi_rd(regs[i], 32'h0, RESP_OKAY);
    axi_rd(8'h14, 32'h0, RESP_SLVERR);
    axi_wr(8'h14, 32'h1, RESP_SLVERR);
    check(34'({ce_n, sel_n, rnw}), 34'h7);
    $display("test reset done");
    axi_wr(REG_IRQ_MASK, 32'h1, RESP_OKAY);
    for (int m = 0; m < 4; m++) begin
      slow <= m[0];
      convert(m[1], m[0]);
    end
    $display("test modes done");
    axi_wr(REG_IRQ_MASK, 32'h3, RESP_OKAY);
    slow <= 1'b1;
    vin <= 8'h5a;
    axi_wr(REG_CTRL, 32'h1, RESP_OKAY);
    axi_wr(REG_CTRL, 32'h7, RESP_OKAY);
    check(34'({bip, fmt, irq}), 34'h1);
    axi_rd(REG_IRQ_STAT, 32'h2, RESP_OKAY);
    axi_wr(REG_IRQ_STAT, 32'h2, RESP_OKAY);
    wait_irq();
    axi_rd(REG_DATA, 32'h5a, RESP_OKAY);
    axi_rd(REG_IRQ_STAT, 32'h1, RESP_OKAY);
    axi_wr(REG_IRQ_MASK, 32'h0, RESP_OKAY);
    check(34'(irq), 34'h0);
    axi_wr(REG_IRQ_STAT, 32'h1, RESP_OKAY);
    axi_rd(REG_IRQ_STAT, 32'h0, RESP_OKAY);
    $display("test busy done");
    print_verdict();
  end
  // A hang counts as a mismatch.
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
